// ==== src/rsw_supervisor_regs.vh ====
// constants for the supervisor: timing, watchdog period codes, tick divider
`ifndef RSW_SUPERVISOR_REGS_VH
`define RSW_SUPERVISOR_REGS_VH
`define RSW_CLK_HZ         50000000
`define RSW_OSC_HZ         32768
`define RSW_RESET_MS       250
`define RSW_WD_SHORT_MS    250
`define RSW_WD_MID_MS      750
`define RSW_WD_LONG_MS     1750
`define RSW_TICKS(ms)      (((ms) * `RSW_OSC_HZ) / 1000)
`define RSW_SEL_OFF        2'h3
`define RSW_SEL_SHORT      2'h2
`define RSW_SEL_MID        2'h1
`define RSW_SEL_LONG       2'h0
`define RSW_POLICY_STD     1'h0
`define RSW_POLICY_LEGACY  1'h1
`define RSW_CNT_W          16
`endif

// ==== src/rsw_tick_gen.v ====
// fractional divider making a one-cycle 32.768 kHz tick from the system clock
`timescale 1ns/1ps
`include "rsw_supervisor_regs.vh"
module rsw_tick_gen #(
	parameter CLK_HZ = `RSW_CLK_HZ,
	parameter OSC_HZ = `RSW_OSC_HZ
) (
	input  wire clk_sys,
	input  wire rst,
	output reg  tick
);
	reg  [31:0] acc;
	wire [32:0] sum = {1'b0, acc} + OSC_HZ;

	// phase accumulator keeps the long-term rate exact, jitter is one cycle
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			acc  <= 32'h0;
			tick <= 1'b0;
		end
		else if (sum >= CLK_HZ)
		begin
			acc  <= sum[31:0] - CLK_HZ;
			tick <= 1'b1;
		end
		else
		begin
			acc  <= sum[31:0];
			tick <= 1'b0;
		end
	end
endmodule // rsw_tick_gen

// ==== src/rsw_supervisor.v ====
// supply switchover, power-on/low-voltage reset and bus watchdog
//
// Notes on behaviour
// - policy bit 0 selects standard switchover with a 2.2 V trip level.
// - policy bit 1 selects legacy switchover: supply against battery only.
// - standard: battery mode needs supply below battery and below trip.
// - standard: back to supply when above battery or above trip level.
// - legacy: battery mode when supply below battery minus hysteresis.
// - battery bus disable bit decides if the bus answers in battery mode.
// - reset active at power-up, released 250 ms after supply is good.
// - memory access blocked while power-on reset is active.
// - period select: 11 off, 10 250 ms, 01 750 ms, 00 1.75 s.
// - watchdog counter held idle when period select is off.
// - each bus START reloads the watchdog to its full period.
// - expiry without START asserts reset for one reset timeout period.
// - a START during a reset timeout period has no effect.
// - watchdog suspended entirely in battery mode.
// - low-voltage reset held until 250 ms after supply recovers.
// - reset raised in battery mode holds until back in supply mode.
`timescale 1ns/1ps
`include "rsw_supervisor_regs.vh"
module rsw_supervisor #(
	parameter CNT_W = `RSW_CNT_W
) (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       supply_switch_policy,
	input  wire       battery_bus_disable,
	input  wire       watchdog_period_sel_hi,
	input  wire       watchdog_period_sel_lo,
	input  wire       vdd_below_bat_hys,
	input  wire       vdd_below_trip,
	input  wire       vdd_above_bat_hys,
	input  wire       vdd_above_trip_hys,
	input  wire       vdd_above_reset,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        battery_mode,
	output reg        reset_n,
	output reg        bus_enable,
	output reg        mem_access_enable,
	output reg        watchdog_active,
	output reg        watchdog_bite
);
	localparam [CNT_W-1:0] RST_TICKS  = `RSW_TICKS(`RSW_RESET_MS);
	localparam [CNT_W-1:0] WD_SHORT   = `RSW_TICKS(`RSW_WD_SHORT_MS);
	localparam [CNT_W-1:0] WD_MID     = `RSW_TICKS(`RSW_WD_MID_MS);
	localparam [CNT_W-1:0] WD_LONG    = `RSW_TICKS(`RSW_WD_LONG_MS);
	localparam [1:0]       ST_HOLD    = 2'h0;
	localparam [1:0]       ST_TIMEOUT = 2'h1;
	localparam [1:0]       ST_RUN     = 2'h2;

	wire             tick;
	wire [1:0]       wd_sel;
	reg  [1:0]       state;
	reg  [1:0]       next_state;
	reg  [CNT_W-1:0] rst_cnt;
	reg  [CNT_W-1:0] wd_cnt;
	reg              scl_d;
	reg              sda_d;
	reg              por_done;
	reg              next_battery;
	wire             start_seen;
	wire             wd_run;

	assign wd_sel = {watchdog_period_sel_hi, watchdog_period_sel_lo};

	// period select decode, used for reload; the enable test compares wd_sel with the off code
	function [CNT_W-1:0] wd_period;
		input [1:0] sel;
		begin
			case (sel)
				`RSW_SEL_SHORT: wd_period = WD_SHORT;
				`RSW_SEL_MID:   wd_period = WD_MID;
				`RSW_SEL_LONG:  wd_period = WD_LONG;
				default:        wd_period = {CNT_W{1'b0}};
			endcase
		end
	endfunction

	rsw_tick_gen u_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// supply switchover; comparator flags arrive already thresholded
	always @*
	begin
		next_battery = battery_mode;
		if (supply_switch_policy == `RSW_POLICY_STD)
		begin
			if (!battery_mode && vdd_below_bat_hys && vdd_below_trip)
				next_battery = 1'b1;
			else if (battery_mode &&
				(vdd_above_bat_hys || vdd_above_trip_hys))
				next_battery = 1'b0;
		end
		else
		begin
			// legacy runs from the higher source, hysteresis both ways
			if (!battery_mode && vdd_below_bat_hys)
				next_battery = 1'b1;
			else if (battery_mode && vdd_above_bat_hys)
				next_battery = 1'b0;
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			battery_mode <= 1'b0;
		else
			battery_mode <= next_battery;
	end

	////////////////////////////////////////////////////////////////////////
	// start detector: sda falls while scl stays high
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_in;
			sda_d <= sda_in;
		end
	end

	assign start_seen = scl_d && scl_in && sda_d && !sda_in;
	assign wd_run = (wd_sel != `RSW_SEL_OFF) && !battery_mode;

	////////////////////////////////////////////////////////////////////////
	// reset sequencer: hold while supply low, then one timeout period
	always @*
	begin
		next_state = state;
		case (state)
			ST_HOLD:
				// battery-mode reset waits for supply mode as well
				if (vdd_above_reset && !battery_mode)
					next_state = ST_TIMEOUT;
			ST_TIMEOUT:
				if (!vdd_above_reset || battery_mode)
					next_state = ST_HOLD;
				else if (tick && rst_cnt == RST_TICKS - 1'b1)
					next_state = ST_RUN;
			ST_RUN:
				if (!vdd_above_reset)
					next_state = ST_HOLD;
				else if (wd_run && tick && wd_cnt == {CNT_W{1'b0}})
					next_state = ST_TIMEOUT;
			default:
				next_state = ST_HOLD;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			state    <= ST_HOLD;
			rst_cnt  <= {CNT_W{1'b0}};
			por_done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (next_state != ST_TIMEOUT || state != ST_TIMEOUT)
				rst_cnt <= {CNT_W{1'b0}};
			else if (tick)
				rst_cnt <= rst_cnt + 1'b1;
			if (state == ST_RUN)
				por_done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog down-counter in oscillator ticks
	always @(posedge clk_sys)
	begin
		if (rst)
			wd_cnt <= {CNT_W{1'b0}};
		else if (!wd_run || state != ST_RUN)
			// idle at full period, zero when off; starts in timeout are ignored
			wd_cnt <= wd_period(wd_sel);
		else if (start_seen)
			wd_cnt <= wd_period(wd_sel);
		else if (tick && wd_cnt != {CNT_W{1'b0}})
			wd_cnt <= wd_cnt - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			reset_n           <= 1'b0;
			bus_enable        <= 1'b0;
			mem_access_enable <= 1'b0;
			watchdog_active   <= 1'b0;
			watchdog_bite     <= 1'b0;
		end
		else
		begin
			reset_n <= (next_state == ST_RUN);
			// bus only off in battery mode when software asks for it
			bus_enable <= !(battery_mode && battery_bus_disable);
			mem_access_enable <= por_done || next_state == ST_RUN;
			watchdog_active <= wd_run && state == ST_RUN;
			watchdog_bite <= state == ST_RUN && next_state == ST_TIMEOUT;
		end
	end
endmodule // rsw_supervisor

// ==== tb/rsw_supervisor_properties.sv ====
// checker: switchover, bus gating and reset hold relations
`timescale 1ns/1ps
module rsw_props (
	input logic clk_sys,
	input logic rst,
	input logic supply_switch_policy,
	input logic battery_bus_disable,
	input logic vdd_below_bat_hys,
	input logic vdd_below_trip,
	input logic vdd_above_bat_hys,
	input logic vdd_above_trip_hys,
	input logic battery_mode,
	input logic reset_n,
	input logic bus_enable,
	input logic mem_access_enable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// standard policy needs both low flags, any one high flag brings it back
	wire pol_std  = !supply_switch_policy;
	wire both_low = vdd_below_bat_hys && vdd_below_trip;
	a_std_enter_batt: assert property (
		pol_std && !battery_mode && both_low |=> battery_mode) else $error("no entry");
	a_std_stay_supply: assert property (
		pol_std && !battery_mode && !both_low |=> !battery_mode) else $error("early");
	a_std_return_supply: assert property (
		pol_std && battery_mode && (vdd_above_bat_hys || vdd_above_trip_hys)
		|=> !battery_mode) else $error("no return");
	a_legacy_enter_batt: assert property (
		!pol_std && !battery_mode && vdd_below_bat_hys |=> battery_mode)
		else $error("legacy no entry");
	a_legacy_no_trip: assert property (
		!pol_std && !battery_mode && !vdd_below_bat_hys |=> !battery_mode)
		else $error("legacy early");
	// two cycles let the registered mode reach the bus gate
	a_batt_bus_off: assert property (
		(battery_mode && battery_bus_disable)[*2] |-> !bus_enable)
		else $error("bus on in battery");
	a_mem_after_reset: assert property (
		$rose(mem_access_enable) |-> reset_n) else $error("memory early");
	a_batt_reset_hold: assert property (
		battery_mode && !reset_n |=> !reset_n) else $error("reset left early");
	cover property (battery_mode && supply_switch_policy);
	cover property ($fell(battery_mode));
	cover property (battery_mode && !bus_enable);
endmodule // rsw_props
bind rsw_supervisor rsw_props u_props (.*);

// ==== tb/rsw_host_model.sv ====
// host model: bus master issuing a lone START followed by a STOP
`timescale 1ns/1ps
module rsw_host (
	input  wire clk_sys,
	input  wire start_req,
	output wire scl,
	output wire sda
);
	reg [2:0] ph = 3'h0;
	// phase counter paces the lines, two clocks per bus step
	always @(posedge clk_sys)
		ph <= (ph != 3'h0 || start_req) ? ph + 3'h1 : 3'h0;
	// lines idle high through pull-ups; the supervisor ignores the STOP and only detects START
	assign sda = (ph == 3'h0 || ph == 3'h7);
	assign scl = !(ph == 3'h3 || ph == 3'h4);
endmodule // rsw_host

// ==== tb/tb_top.sv ====
// testbench for the supervisor: switchover, bus gating, power-on hold
`timescale 1ns/1ps
module tb_top;
	reg clk_sys = 1'b0, rst = 1'b1, start_req = 1'b0;
	reg supply_switch_policy = 1'b0, battery_bus_disable = 1'b0;
	reg watchdog_period_sel_hi = 1'b1, watchdog_period_sel_lo = 1'b0;
	reg vdd_below_bat_hys = 1'b0, vdd_below_trip = 1'b0;
	reg vdd_above_bat_hys = 1'b1, vdd_above_trip_hys = 1'b1;
	reg vdd_above_reset = 1'b1;
	wire scl_in, sda_in, battery_mode, reset_n, bus_enable;
	wire mem_access_enable, watchdog_active, watchdog_bite;
	integer errors = 0, checked = 0;
	rsw_supervisor DUT (.*);
	// one tick per clock so that the 8192-tick periods fit in the run
	defparam DUT.u_tick.CLK_HZ = 32768;
	rsw_host u_host (.clk_sys(clk_sys), .start_req(start_req),
		.scl(scl_in), .sda(sda_in));
	always #10 clk_sys = !clk_sys;
	////////////////////////////////////////////////////////////////////////
	task check(input logic got, input logic exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("unexpected at %0t: got %b want %b", $time, got, exp);
		end
	end
	endtask
	// drive policy, bus-off bit and comparator flags, then judge the mode
	task step(input [6:0] v, input logic exp);
	begin
		@(posedge clk_sys);
		{supply_switch_policy, battery_bus_disable, vdd_above_reset,
			vdd_below_bat_hys, vdd_below_trip, vdd_above_bat_hys,
			vdd_above_trip_hys} <= v;
		repeat (2) @(posedge clk_sys);
		#1;
		check(battery_mode, exp);
	end
	endtask
	// the 8192-tick release delay is beyond this 2000-cycle wait, so only the hold shows
	task t_power_on;
	begin
		@(posedge clk_sys) start_req <= 1'b1;
		@(posedge clk_sys) start_req <= 1'b0;
		repeat (2000) @(posedge clk_sys);
		#1;
		check(reset_n, 1'b0);
		check(mem_access_enable, 1'b0);
	end
	endtask
	task t_standard;
	begin
		step(7'h18, 1'b0);
		step(7'h14, 1'b0);
		step(7'h1C, 1'b1);
		step(7'h11, 1'b0);
		step(7'h1C, 1'b1);
		step(7'h12, 1'b0);
	end
	endtask
	task t_legacy;
	begin
		step(7'h54, 1'b0);
		step(7'h58, 1'b1);
		check(bus_enable, 1'b1);
		step(7'h78, 1'b1);
		check(bus_enable, 1'b0);
		step(7'h68, 1'b1);
		step(7'h58, 1'b1);
		check(reset_n, 1'b0);
		step(7'h52, 1'b0);
	end
	endtask
	// release, refresh by START, expiry, timeout with a START inside, off
	task t_watchdog;
		integer n;
	begin
		n = 0;
		repeat (8300) @(posedge clk_sys);
		#1;
		check(reset_n, 1'b1);
		check(mem_access_enable, 1'b1);
		check(watchdog_active, 1'b1);
		@(posedge clk_sys) start_req <= 1'b1;
		@(posedge clk_sys) start_req <= 1'b0;
		repeat (8150) @(posedge clk_sys);
		#1;
		check(reset_n, 1'b1);
		repeat (200)
		begin
			@(posedge clk_sys);
			#1;
			if (watchdog_bite === 1'b1)
				n = n + 1;
		end
		check(n == 1, 1'b1);
		check(reset_n, 1'b0);
		@(posedge clk_sys) start_req <= 1'b1;
		@(posedge clk_sys) start_req <= 1'b0;
		repeat (7800) @(posedge clk_sys);
		#1;
		check(reset_n, 1'b0);
		repeat (300) @(posedge clk_sys);
		#1;
		check(reset_n, 1'b1);
		@(posedge clk_sys) watchdog_period_sel_lo <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check(watchdog_active, 1'b0);
	end
	endtask
	////////////////////////////////////////////////////////////////////////
	task close_out;
	begin
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// the tests need under 28000 cycles; the limit leaves ample margin
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		errors = errors + 1;
		close_out;
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		t_power_on;
		t_standard;
		t_legacy;
		t_watchdog;
		close_out;
	end
endmodule // tb_top
